// File: verilog/ctm_pkg.sv
/*
 Constants and types shared by both ends of the cache tag array maintenance block.
 Assumes a single 20 MHz system clock and a synchronous active-high reset.
*/
package ctm_pkg;
   localparam int          CTM_WAYS      = 4;
   localparam int          CTM_ENTRIES   = 64;
   localparam int          CTM_TAG_W     = 19;
   localparam int          CTM_LRU_W     = 6;
   // Address regions (top three bits)
   localparam logic [2:0]  CTM_RGN_TAG   = 3'h3;
   localparam logic [2:0]  CTM_RGN_PURGE = 3'h2;
   localparam logic [2:0]  CTM_RGN_DATA  = 3'h6;
   localparam logic [2:0]  CTM_RGN_THRU  = 3'h1;
   localparam logic [31:0] CTM_TAG_BASE  = 32'h6000_0000;
   localparam logic [31:0] CTM_TAG_LAST  = 32'h6000_03FF;
   localparam logic [31:0] CTM_PURGE_OFS = 32'h4000_0000;
   // Field positions
   localparam int          CTM_TAG_LSB   = 10;
   localparam int          CTM_IDX_LSB   = 4;
   localparam int          CTM_LRU_LSB   = 4;
   localparam int          CTM_VAL_BIT   = 2;
   // Control register bits
   localparam int          CTM_CR_WSH    = 7;
   localparam int          CTM_CR_WSL    = 6;
   localparam int          CTM_CR_TWO    = 3;
   localparam int          CTM_CR_PURGE  = 4;
   localparam int          CTM_CR_ODIS   = 2;
   localparam int          CTM_CR_IDIS   = 1;
   localparam int          CTM_CR_EN     = 0;
   localparam logic [7:0]  CTM_CR_RST    = 8'h00;
   localparam logic [7:0]  CTM_CR_WMASK  = 8'hEF;
   // Wishbone register offsets on the controller
   localparam logic [3:0]  CTM_WB_CMD    = 4'h0;
   localparam logic [3:0]  CTM_WB_ADDR   = 4'h4;
   localparam logic [3:0]  CTM_WB_WDATA  = 4'h8;
   localparam logic [3:0]  CTM_WB_STAT   = 4'hC;
   localparam logic [1:0]  CTM_SZ_LONG   = 2'h2;

   typedef enum logic [1:0] {
      CTM_K_FETCH = 2'b00,
      CTM_K_LOAD  = 2'b01,
      CTM_K_STORE = 2'b10,
      CTM_K_TAS   = 2'b11
   } ctm_kind_e;
endpackage

// File: verilog/ctm_link_if.sv
/*
 Link between the CPU-side maintenance master and the cache maintenance device.
 Assumes one clock; the master holds a request until ack.
*/
`timescale 1ns/10ps
interface ctm_link_if;
   logic        req;
   logic        we;
   logic [1:0]  size;
   logic [1:0]  kind;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic        ack;
   logic [31:0] rdata;
   logic        err;
   logic        bypass;
   logic        alloc_ok;
   logic [1:0]  fill_way;
   logic        lru_upd;
   logic        hit;
   modport dev (input req, we, size, kind, addr, wdata,
                output ack, rdata, err, bypass, alloc_ok, fill_way, hit, input lru_upd);
   modport cpu (output req, we, size, kind, addr, wdata, lru_upd,
                input ack, rdata, err, bypass, alloc_ok, fill_way, hit);
endinterface

// File: verilog/ctm_cache_maint.sv
/*
 Cache tag array maintenance device: tag window, purge-all, associative purge,
 two-way mode and allocation policy. Assumes the link master holds a request
 until ack and releases it for at least one cycle afterwards.
*/
`timescale 1ns/10ps
module ctm_cache_maint #(
   parameter int TAG_W = ctm_pkg::CTM_TAG_W,
   parameter int LRU_W = ctm_pkg::CTM_LRU_W
) (
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       ce_i,
   input  wire logic       cr_we_i,
   input  wire logic [7:0] cr_wdata_i,
   output logic      [7:0] cr_o,
   ctm_link_if.dev         lnk
);
   logic [TAG_W-1:0] tag_mem   [ctm_pkg::CTM_WAYS][ctm_pkg::CTM_ENTRIES];
   logic             valid_mem [ctm_pkg::CTM_WAYS][ctm_pkg::CTM_ENTRIES];
   logic [LRU_W-1:0] lru_mem   [ctm_pkg::CTM_ENTRIES];
   logic [7:0]       cr;
   logic             busy;
   logic [2:0]       rgn;
   logic [5:0]       idx;
   logic [1:0]       wsel;
   logic [3:0]       match;
   logic             purge_all;
   logic             in_tag;
   logic             in_purge;
   logic             in_thru;
   logic             is_long;
   logic             take;
   logic             tag_wr;
   logic             purge_go;
   logic             lru_go;
   logic [31:0]      next_rdata;
   logic             next_err;
   logic             next_bypass;
   logic             next_alloc;

   // Region decode shared by every access kind
   function automatic logic ctm_is_rgn(input logic [2:0] r, input logic [2:0] c);
      ctm_is_rgn = r == c;
   endfunction

   function automatic logic [1:0] ctm_victim(input logic [5:0] l, input logic two);
      if (two)
         ctm_victim = l[0] ? 2'h2 : 2'h3;
      else if (l[5] & l[4] & l[3])
         ctm_victim = 2'h0;
      else if (!l[5] & l[2] & l[1])
         ctm_victim = 2'h1;
      else if (!l[4] & !l[2] & l[0])
         ctm_victim = 2'h2;
      else
         ctm_victim = 2'h3;
   endfunction

   function automatic logic [5:0] ctm_lru_upd(input logic [5:0] l, input logic [1:0] w);
      unique case (w)
         2'h0: ctm_lru_upd = {3'b000, l[2:0]};
         2'h1: ctm_lru_upd = {1'b1, l[4:3], 2'b00, l[0]};
         2'h2: ctm_lru_upd = {l[5], 1'b1, l[3], 1'b1, l[1], 1'b0};
         2'h3: ctm_lru_upd = {l[5:4], 1'b1, l[2], 2'b11};
      endcase
   endfunction

   assign rgn       = lnk.addr[31:29];
   assign idx       = lnk.addr[ctm_pkg::CTM_IDX_LSB +: 6];
   assign wsel      = {cr[ctm_pkg::CTM_CR_WSH], cr[ctm_pkg::CTM_CR_WSL]};
   assign purge_all = cr_we_i & cr_wdata_i[ctm_pkg::CTM_CR_PURGE];
   assign cr_o      = cr;
   assign in_tag    = ctm_is_rgn(rgn, ctm_pkg::CTM_RGN_TAG);
   assign in_purge  = ctm_is_rgn(rgn, ctm_pkg::CTM_RGN_PURGE);
   assign in_thru   = ctm_is_rgn(rgn, ctm_pkg::CTM_RGN_THRU);
   assign is_long   = lnk.size == ctm_pkg::CTM_SZ_LONG;
   assign take      = lnk.req && !busy;
   assign tag_wr    = take && is_long && in_tag && lnk.we;
   assign purge_go  = take && is_long && in_purge;
   assign lru_go    = take && lnk.lru_upd && !(is_long && (in_tag || in_purge));

   // Way match against the tag field of the address
   always_comb begin
      for (int w = 0; w < ctm_pkg::CTM_WAYS; w++)
         match[w] = valid_mem[w][idx] &&
                    tag_mem[w][idx] == lnk.addr[ctm_pkg::CTM_TAG_LSB +: TAG_W];
   end

   // Answer values for the request now taken
   always_comb begin
      next_err    = (in_tag || in_purge) && !is_long;
      next_rdata  = '0;
      if (in_tag)
         next_rdata = {3'h0, tag_mem[wsel][idx], lru_mem[idx], 1'b0, valid_mem[wsel][idx],
                       2'h0};
      next_bypass = in_thru || lnk.kind == ctm_pkg::CTM_K_TAS;
      next_alloc  = cr[ctm_pkg::CTM_CR_EN] && rgn == 3'h0 &&
                    lnk.kind != ctm_pkg::CTM_K_TAS &&
                    !(cr[ctm_pkg::CTM_CR_ODIS] && lnk.kind != ctm_pkg::CTM_K_FETCH);
   end

   // Control register; purge bit is a strobe and reads as zero
   always_ff @(posedge clk_i) begin
      if (sys_rst_i)
         cr <= ctm_pkg::CTM_CR_RST;
      else if (ce_i && cr_we_i)
         cr <= cr_wdata_i & ctm_pkg::CTM_CR_WMASK;
   end

   // Valid bits; no reset term, so contents survive reset
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (purge_all) begin
            for (int e = 0; e < ctm_pkg::CTM_ENTRIES; e++)
               for (int w = 0; w < ctm_pkg::CTM_WAYS; w++)
                  valid_mem[w][e] <= 1'b0;
         end else if (tag_wr) begin
            valid_mem[wsel][idx] <= lnk.addr[ctm_pkg::CTM_VAL_BIT];
         end else if (purge_go) begin
            for (int w = 0; w < ctm_pkg::CTM_WAYS; w++)
               if (match[w])
                  valid_mem[w][idx] <= 1'b0;
         end
      end
   end

   // Tags; written only through the tag window, tag taken from the address
   always_ff @(posedge clk_i) begin
      if (ce_i && tag_wr)
         tag_mem[wsel][idx] <= lnk.addr[ctm_pkg::CTM_TAG_LSB +: TAG_W];
   end

   // LRU field; purge-all beats any link access in the same cycle
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (purge_all) begin
            for (int e = 0; e < ctm_pkg::CTM_ENTRIES; e++)
               lru_mem[e] <= '0;
         end else if (tag_wr) begin
            lru_mem[idx] <= lnk.wdata[ctm_pkg::CTM_LRU_LSB +: LRU_W];
         end else if (lru_go) begin
            lru_mem[idx] <= ctm_lru_upd(lru_mem[idx], lnk.fill_way);
         end
      end
   end

   // Request handshake: one ack per accepted request, then one idle cycle
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         busy    <= 1'b0;
         lnk.ack <= 1'b0;
      end else if (ce_i) begin
         busy    <= take;
         lnk.ack <= take;
      end
   end

   // Read data of the tag window
   always_ff @(posedge clk_i) begin
      if (sys_rst_i)
         lnk.rdata <= '0;
      else if (ce_i && take)
         lnk.rdata <= next_rdata;
   end

   // Size refusal flag
   always_ff @(posedge clk_i) begin
      if (sys_rst_i)
         lnk.err <= 1'b0;
      else if (ce_i && take)
         lnk.err <= next_err;
   end

   // Hit flag; foreign masters have no port here, so nothing snoops
   always_ff @(posedge clk_i) begin
      if (sys_rst_i)
         lnk.hit <= 1'b0;
      else if (ce_i && take)
         lnk.hit <= |match;
   end

   // Bypass flag
   always_ff @(posedge clk_i) begin
      if (sys_rst_i)
         lnk.bypass <= 1'b0;
      else if (ce_i && take)
         lnk.bypass <= next_bypass;
   end

   // Allocation permission
   always_ff @(posedge clk_i) begin
      if (sys_rst_i)
         lnk.alloc_ok <= 1'b0;
      else if (ce_i && take)
         lnk.alloc_ok <= next_alloc;
   end

   // Replacement way
   always_ff @(posedge clk_i) begin
      if (sys_rst_i)
         lnk.fill_way <= 2'h3;
      else if (ce_i && take)
         lnk.fill_way <= ctm_victim(lru_mem[idx], cr[ctm_pkg::CTM_CR_TWO]);
   end

   // Two-way RAM of ways 0,1 lives in the data array window, not here
endmodule

// File: verilog/ctm_cpu_master.sv
/*
 CPU-side end: Wishbone-driven command registers issue maintenance accesses on the link.
 Assumes the device answers each request with a single ack pulse.
*/
`timescale 1ns/10ps
module ctm_cpu_master (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        ce_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   ctm_link_if.cpu          lnk
);
   logic [31:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        done;
   logic        err;
   logic        wb_go;

   assign wb_go = wb_cyc_i && wb_stb_i && !wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else if (ce_i) begin
         wb_ack_o <= wb_go;
         unique case (wb_adr_i)
            ctm_pkg::CTM_WB_ADDR:  wb_dat_o <= addr;
            ctm_pkg::CTM_WB_WDATA: wb_dat_o <= wdata;
            ctm_pkg::CTM_WB_STAT:  wb_dat_o <= {29'h0, err, lnk.req, done};
            ctm_pkg::CTM_WB_CMD:   wb_dat_o <= rdata;
            default:               wb_dat_o <= '0;
         endcase
      end
   end

   // Command word: bit0 we, bits 2:1 size, bits 4:3 kind; writing it starts an access
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         addr      <= '0;
         wdata     <= '0;
         rdata     <= '0;
         done      <= 1'b0;
         err       <= 1'b0;
         lnk.req   <= 1'b0;
         lnk.we    <= 1'b0;
         lnk.size  <= ctm_pkg::CTM_SZ_LONG;
         lnk.kind  <= ctm_pkg::CTM_K_LOAD;
         lnk.addr  <= '0;
         lnk.wdata <= '0;
         lnk.lru_upd <= 1'b0;
      end else if (ce_i) begin
         if (wb_go && wb_we_i && wb_sel_i == 4'hF) begin
            unique case (wb_adr_i)
               ctm_pkg::CTM_WB_ADDR:  addr  <= wb_dat_i;
               ctm_pkg::CTM_WB_WDATA: wdata <= wb_dat_i;
               ctm_pkg::CTM_WB_CMD: if (!lnk.req) begin
                  lnk.req   <= 1'b1;
                  lnk.we    <= wb_dat_i[0];
                  lnk.size  <= wb_dat_i[2:1];
                  lnk.kind  <= wb_dat_i[4:3];
                  lnk.addr  <= addr;
                  lnk.wdata <= wdata;
                  done      <= 1'b0;
               end
               default: ;
            endcase
         end else if (lnk.req && lnk.ack) begin
            lnk.req <= 1'b0;
            rdata   <= lnk.rdata;
            err     <= lnk.err;
            done    <= 1'b1;
         end
      end
   end
   // Software sequencing duties (standby, control changes, data window) lie above
endmodule

// File: test/ctm_link_asserts.sv
/*
 Concurrent checks on the link between the two ends.
 Assumes instantiation beside the link interface, one clock, sync reset.
*/
`timescale 1ns/10ps
module ctm_link_asserts (
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   input wire logic        req,
   input wire logic [1:0]  size,
   input wire logic [1:0]  kind,
   input wire logic [31:0] addr,
   input wire logic        ack,
   input wire logic        err,
   input wire logic        bypass,
   input wire logic        alloc_ok
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   a_tag_size_err: assert property (ack && addr[31:29] == 3'h3 && size != 2'h2 |-> err)
      else $error("short tag access not refused");
   a_tag_long_ok: assert property (ack && addr[31:29] == 3'h3 && size == 2'h2 |-> !err)
      else $error("longword tag access refused");
   a_thru_alloc: assert property (ack && addr[31:29] == 3'h1 |-> !alloc_ok)
      else $error("cache-through access allocated");
   a_tas_bypass: assert property (ack && kind == 2'h3 |-> bypass)
      else $error("test-and-set read not bypassed");
   a_purge_answer: assert property ($rose(req) && addr[31:29] == 3'h2 |=> ack && !alloc_ok)
      else $error("purge access not answered");
   a_tag_answer: assert property ($rose(req) && addr[31:29] == 3'h3 |=> ack ##1 !ack)
      else $error("tag access not answered once");
   a_ack_release: assert property (ack |=> !req)
      else $error("request held after ack");
   a_req_stable: assert property (req && !ack |=> $stable(addr) && $stable(kind))
      else $error("request changed before ack");
   c_err: cover property (ack && err);
   c_byp: cover property (ack && bypass);
   c_alloc: cover property (ack && alloc_ok);
endmodule

// File: test/cache_tag_array_maintenance_tb_top.sv
/*
 Bench joining both ends over the link; drives Wishbone and the control port.
 Assumes command bits [0] write, [2:1] size, [4:3] kind.
*/
`timescale 1ns/10ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin mismatches++; \
   $display("Error %s exp %0h got %0h", n, e, s); end end
module cache_tag_array_maintenance_tb_top;
   localparam logic [31:0] M = 32'h1FFFFFF4;
   logic        clk_i = 0;
   logic        sys_rst_i = 1;
   logic        cr_we_i = 0;
   logic [7:0]  cr_wdata_i = 8'h00;
   logic [7:0]  cr_o;
   logic        wb_cyc_i = 0;
   logic        wb_stb_i = 0;
   logic        wb_we_i = 0;
   logic [3:0]  wb_adr_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic [31:0] seed = 32'h13A13D1A;
   logic [31:0] q;
   logic [18:0] tg [4];
   logic [5:0]  ix;
   logic [4:0]  seen;
   int          mismatches = 0;
   int          num_checks = 0;
   ctm_link_if lnk ();
   ctm_cache_maint i_ctm_cache_maint (.clk_i, .sys_rst_i, .ce_i(1'b1), .cr_we_i, .cr_wdata_i,
      .cr_o, .lnk(lnk));
   ctm_cpu_master i_ctm_cpu_master (.clk_i, .sys_rst_i, .ce_i(1'b1), .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .lnk(lnk));
   ctm_link_asserts i_ctm_link_asserts (.clk_i, .sys_rst_i, .req(lnk.req), .size(lnk.size),
      .kind(lnk.kind), .addr(lnk.addr), .ack(lnk.ack), .err(lnk.err), .bypass(lnk.bypass),
      .alloc_ok(lnk.alloc_ok));
   always #25 clk_i = ~clk_i;
   // Link answer flags captured in the ack cycle
   always @(posedge clk_i) if (lnk.ack === 1'b1) seen <= {lnk.hit, lnk.err, lnk.bypass, lnk.alloc_ok,
      lnk.fill_way[0]};
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [4:0] cm(ctm_pkg::ctm_kind_e k, logic w);
      return {k, ctm_pkg::CTM_SZ_LONG, w};
   endfunction
   // Tag window address; low two bits set, they must be ignored
   function automatic logic [31:0] ta(logic [18:0] t, logic [5:0] i, logic v);
      return {3'h3, t, i, 1'b0, v, 2'h3};
   endfunction
   function automatic logic [31:0] ex(logic [18:0] t, logic v);
      return {3'h0, t, 6'h00, 1'b0, v, 2'h0};
   endfunction
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
   endtask
   task automatic op(input logic [4:0] c, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb(1, ctm_pkg::CTM_WB_ADDR, a);
      wb(1, ctm_pkg::CTM_WB_WDATA, d);
      wb(1, ctm_pkg::CTM_WB_CMD, {27'h0, c});
      do begin
         wb(0, ctm_pkg::CTM_WB_STAT, 0);
         n++;
      end while (q[0] !== 1'b1 && n < 20);
      wb(0, ctm_pkg::CTM_WB_CMD, 0);
   endtask
   task automatic crw(input logic [7:0] v);
      @(posedge clk_i);
      cr_we_i <= 1;
      cr_wdata_i <= v;
      @(posedge clk_i);
      cr_we_i <= 0;
      @(posedge clk_i);
   endtask
   task automatic rdw(input logic [7:0] c);
      crw(c);
      op(cm(ctm_pkg::CTM_K_LOAD, 0), ta(0, ix, 0), 0);
   endtask
   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #1000000;
      mismatches++;
      tally_and_finish();
   end
   initial begin
      repeat (16) @(posedge clk_i);
      sys_rst_i <= 0;
      @(posedge clk_i);
      `CHK("ctrl", 8'h00, cr_o)
      q = rnd();
      ix = q[5:0];
      for (int w = 0; w < 4; w++) begin
         q = rnd();
         tg[w] = {q[16:0], 2'(w)};
         crw({2'(w), 6'h00});
         op(cm(ctm_pkg::CTM_K_STORE, 1), ta(tg[w], ix, 1), 0);
      end
      for (int w = 0; w < 4; w++) begin
         rdw({2'(w), 6'h00});
         `CHK("tag", ex(tg[w], 1), q & M)
      end
      crw(8'hC1);
      sys_rst_i <= 1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 0;
      @(posedge clk_i);
      `CHK("ctrl", 8'h00, cr_o)
      op({2'b01, 2'b01, 1'b1}, ta(~tg[0], ix, 0), 0);
      `CHK("err", 1'b1, seen[3])
      rdw(8'hC0);
      `CHK("tag", ex(tg[3], 1), q & M)
      rdw(8'h00);
      `CHK("tag", ex(tg[0], 1), q & M)
      op(cm(ctm_pkg::CTM_K_LOAD, 0), {3'h0, tg[1] ^ 19'h4, ix, 4'h0} + 32'h4000_0000, 0);
      `CHK("nohit", 1'b0, seen[4])
      rdw(8'h40);
      `CHK("miss", ex(tg[1], 1), q & M)
      op(cm(ctm_pkg::CTM_K_STORE, 1), {3'h0, tg[1], ix, 4'h0} + 32'h4000_0000, 0);
      `CHK("hit", 1'b1, seen[4])
      rdw(8'h40);
      `CHK("purge", ex(tg[1], 0), q & M)
      rdw(8'h80);
      `CHK("other", ex(tg[2], 1), q & M)
      crw(8'h08);
      crw(8'h18);
      `CHK("ctrl", 8'h08, cr_o)
      for (int w = 0; w < 4; w++) begin
         rdw({2'(w), 6'h08});
         `CHK("clear", 32'h0, q & 32'h3F4)
      end
      crw(8'h09);
      op(cm(ctm_pkg::CTM_K_FETCH, 0), 32'h0000_1230, 0);
      `CHK("fill", 5'b00011, seen)
      crw(8'h00);
      crw(8'h01);
      op(cm(ctm_pkg::CTM_K_FETCH, 0), 32'h2000_1230, 0);
      `CHK("thru", 1'b0, seen[1])
      op(cm(ctm_pkg::CTM_K_TAS, 0), 32'h0000_2000, 0);
      `CHK("tas", 1'b1, seen[2])
      crw(8'h04);
      crw(8'h05);
      op(cm(ctm_pkg::CTM_K_LOAD, 0), 32'h0000_1240, 0);
      `CHK("odis", 1'b0, seen[1])
      op(cm(ctm_pkg::CTM_K_FETCH, 0), 32'h0000_1250, 0);
      `CHK("fetch", 1'b1, seen[1])
      tally_and_finish();
   end
endmodule
